// ### pkg/wde_pkg.sv
package wde_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] WDE_DOG_CTL_ADDR = 8'h0a;
    localparam logic [7:0] WDE_EVT_CTL_ADDR = 8'h0b;
    localparam logic [7:0] WDE_DOG_CTL_RST = 8'h00;
    localparam logic [7:0] WDE_EVT_CTL_RST = 8'h00;

    // watchdog_control fields
    localparam int WDE_DOG_EN_BIT = 7;
    localparam int WDE_DOG_FLAG_BIT = 6;
    localparam int WDE_DOG_DLY_BIT = 5;
    localparam int WDE_DOG_PWS_BIT = 4;
    localparam int WDE_DOG_PER_MSB = 3;
    localparam int WDE_DOG_PER_LSB = 0;

    // event_control fields
    localparam int WDE_FAST_FLAG_BIT = 7;
    localparam int WDE_SLOW_FLAG_BIT = 6;
    localparam int WDE_FAST_EN_BIT = 5;
    localparam int WDE_SLOW_EN_BIT = 4;
    localparam int WDE_CLR_IN_BIT = 3;
    localparam int WDE_DEB_SEL_BIT = 2;
    localparam int WDE_CNT_SEL_MSB = 1;
    localparam int WDE_CNT_SEL_LSB = 0;

    // ----------------------------------------
    // oscillator cycle counts
    // ----------------------------------------
    localparam int WDE_DOG_CW = 22;
    localparam logic [21:0] WDE_DELAY_CYC = 22'h200000;
    localparam logic [12:0] WDE_PULSE_SHORT = 13'h0004;
    localparam logic [12:0] WDE_PULSE_LONG = 13'h1000;
    localparam logic [13:0] WDE_WINDOW_CYC = 14'h2000;
    localparam logic [14:0] WDE_DEB_SHORT = 15'h0400;
    localparam logic [14:0] WDE_DEB_LONG = 15'h4000;

    // reserved codes 1xxx alias onto the low three bits
    function automatic logic [21:0] wde_dog_period(input logic [2:0] sel);
        case (sel)
            3'h0: wde_dog_period = 22'h000020;
            3'h1: wde_dog_period = 22'h000200;
            3'h2: wde_dog_period = 22'h000800;
            3'h3: wde_dog_period = 22'h001000;
            3'h4: wde_dog_period = 22'h008000;
            3'h5: wde_dog_period = 22'h080000;
            3'h6: wde_dog_period = 22'h100000;
            default: wde_dog_period = 22'h200000;
        endcase
    endfunction : wde_dog_period

    function automatic logic [5:0] wde_edges_needed(input logic [1:0] sel);
        case (sel)
            2'h0: wde_edges_needed = 6'h01;
            2'h1: wde_edges_needed = 6'h04;
            2'h2: wde_edges_needed = 6'h10;
            default: wde_edges_needed = 6'h20;
        endcase
    endfunction : wde_edges_needed

endpackage : wde_pkg

// ### pkg/wde_ev_if.sv
`timescale 1ns/1ns
interface wde_ev_if;
    logic tick;
    logic fast_on;
    logic slow_on;
    logic deb_sel;
    logic [1:0] cnt_sel;
    logic fast_edge;
    logic fast_hit;
    logic slow_hit;
    modport core (
        output tick,
        output fast_on,
        output slow_on,
        output deb_sel,
        output cnt_sel,
        input fast_edge,
        input fast_hit,
        input slow_hit
    );
    modport det (
        input tick,
        input fast_on,
        input slow_on,
        input deb_sel,
        input cnt_sel,
        output fast_edge,
        output fast_hit,
        output slow_hit
    );
endinterface : wde_ev_if

// ### src/wde_evdet.sv
`timescale 1ns/1ns
module wde_evdet
    import wde_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic fast_event_input,
    input wire logic slow_event_input,
    wde_ev_if.det ev
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic fs1_reg, fs2_reg, fs3_reg;
    logic ss1_reg, ss2_reg;
    logic fast_edge;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fs1_reg <= 1'b0;
            fs2_reg <= 1'b0;
            fs3_reg <= 1'b0;
            ss1_reg <= 1'b0;
            ss2_reg <= 1'b0;
        end
        else
        begin
            fs1_reg <= fast_event_input;
            fs2_reg <= fs1_reg;
            fs3_reg <= fs2_reg;
            ss1_reg <= slow_event_input;
            ss2_reg <= ss1_reg;
        end
    end

    // both directions count as one transition
    assign fast_edge = fs2_reg ^ fs3_reg;

    // ----------------------------------------
    // fast edge counter with window
    // ----------------------------------------
    logic [5:0] ecnt_reg;
    logic [13:0] win_reg;
    logic [5:0] ecnt_inc;
    logic fast_done;
    logic fast_hit_reg, fast_edge_reg;

    assign ecnt_inc = 6'(ecnt_reg + 6'h01);
    assign fast_done = fast_edge && (ecnt_inc == wde_edges_needed(ev.cnt_sel));

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ecnt_reg <= 6'h00;
            win_reg <= 14'h0000;
        end
        else if (!ev.fast_on)
        begin
            ecnt_reg <= 6'h00;
            win_reg <= 14'h0000;
        end
        else if (fast_edge)
        begin
            ecnt_reg <= fast_done ? 6'h00 : ecnt_inc;
            if (ecnt_reg == 6'h00)
                win_reg <= 14'h0000;
        end
        // window only advances on oscillator ticks
        else if (ecnt_reg != 6'h00 && ev.tick)
        begin
            if (win_reg == 14'(WDE_WINDOW_CYC - 14'h0001))
            begin
                ecnt_reg <= 6'h00;
                win_reg <= 14'h0000;
            end
            else
                win_reg <= 14'(win_reg + 14'h0001);
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fast_hit_reg <= 1'b0;
            fast_edge_reg <= 1'b0;
        end
        else
        begin
            fast_hit_reg <= ev.fast_on && fast_done;
            fast_edge_reg <= fast_edge;
        end
    end

    // ----------------------------------------
    // slow debounce
    // ----------------------------------------
    logic lvl_reg;
    logic [14:0] dcnt_reg;
    logic slow_hit_reg;
    logic [14:0] deb_per;

    assign deb_per = ev.deb_sel ? WDE_DEB_LONG : WDE_DEB_SHORT;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lvl_reg <= 1'b0;
            dcnt_reg <= 15'h0000;
            slow_hit_reg <= 1'b0;
        end
        else
        begin
            slow_hit_reg <= 1'b0;
            if (!ev.slow_on)
            begin
                lvl_reg <= ss2_reg;
                dcnt_reg <= 15'h0000;
            end
            // back at the old level: abandon without a flag
            else if (ss2_reg == lvl_reg)
                dcnt_reg <= 15'h0000;
            // expiry needs oscillator ticks
            else if (ev.tick)
            begin
                if (dcnt_reg == 15'(deb_per - 15'h0001))
                begin
                    lvl_reg <= ss2_reg;
                    dcnt_reg <= 15'h0000;
                    slow_hit_reg <= 1'b1;
                end
                else
                    dcnt_reg <= 15'(dcnt_reg + 15'h0001);
            end
        end
    end

    assign ev.fast_hit = fast_hit_reg;
    assign ev.fast_edge = fast_edge_reg;
    assign ev.slow_hit = slow_hit_reg;

endmodule : wde_evdet

// ### src/wde_top.sv
`timescale 1ns/1ns
// Contract
// - at timeout set the dog flag and pulse the dog pin low once
// - pulse width select picks 4 or 4096 oscillator cycles
// - dog pulse is produced whatever alarms share the pin
// - period field picks 32 up to 2097152 cycles; 1xxx reserved
// - delay enable waits 2097152 cycles after each restart before counting
// - clear instruction from the host restarts the dog count
// - turning the enable off then on clears the count
// - dog flag holds until written clear; clearing it restarts the dog
// - dog enable is cleared while on backup power
// - both event detectors are off while on backup power
// - fast detector counts both edge directions, sets flag, asserts irq
// - count select needs 1, 4, 16 or 32 edges
// - edge count restarts if not reached within 8192 cycles
// - window expiry needs the oscillator running
// - clear-by-input: each fast edge clears dog, fast detector disabled
// - debounce select picks 1024 or 16384 cycles
// - any slow edge starts debounce; expiry sets flag and asserts irq
// - return to prior level before expiry abandons count, flag unchanged
// - debounce never expires while the oscillator is stopped
// - dog never times out while the oscillator is stopped
// - event flags stay set until software writes them clear
// - irq low while any enabled event flag is set
module wde_top
    import wde_pkg::*;
#(
    parameter logic [21:0] DELAY_CYC = WDE_DELAY_CYC
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic osc_tick,
    input wire logic on_backup,
    input wire logic clear_dog_instruction,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic fast_event_input,
    input wire logic slow_event_input,
    output logic dog_output_pin_n,
    output logic irq_n
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    typedef enum logic [1:0] {
        WDE_WD_OFF,
        WDE_WD_DELAY,
        WDE_WD_COUNT,
        WDE_WD_TRIPPED
    } wde_wd_state_t;

    wde_ev_if ev ();

    logic dog_enable_reg;
    logic dog_timeout_flag_reg;
    logic dog_startup_delay_en_reg;
    logic dog_pulse_width_sel_reg;
    logic [3:0] dog_period_sel_reg;
    logic fast_event_flag_reg;
    logic slow_event_flag_reg;
    logic fast_event_enable_reg;
    logic slow_event_enable_reg;
    logic fast_input_clears_dog_reg;
    logic debounce_period_sel_reg;
    logic [1:0] fast_edge_count_sel_reg;
    logic [7:0] reg_rdata_reg;

    wde_wd_state_t wd_state_reg;
    logic [21:0] wd_cnt_reg;
    logic dog_en_prev_reg;
    logic [12:0] pulse_cnt_reg;
    logic pulse_on_reg;
    logic dog_pin_n_reg;
    logic irq_n_reg;

    logic wr_dog;
    logic wr_evt;
    logic dog_flag_clr;
    logic fast_flag_clr;
    logic slow_flag_clr;
    logic dog_restart;
    logic dog_timeout;
    logic [21:0] dog_period;
    logic [12:0] pulse_len;

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    assign wr_dog = reg_wr && (reg_addr == WDE_DOG_CTL_ADDR);
    assign wr_evt = reg_wr && (reg_addr == WDE_EVT_CTL_ADDR);

    // flags are cleared by writing zero; a one written is ignored
    assign dog_flag_clr = wr_dog && !reg_wdata[WDE_DOG_FLAG_BIT];
    assign fast_flag_clr = wr_evt && !reg_wdata[WDE_FAST_FLAG_BIT];
    assign slow_flag_clr = wr_evt && !reg_wdata[WDE_SLOW_FLAG_BIT];

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            dog_enable_reg <= WDE_DOG_CTL_RST[WDE_DOG_EN_BIT];
            dog_startup_delay_en_reg <= WDE_DOG_CTL_RST[WDE_DOG_DLY_BIT];
            dog_pulse_width_sel_reg <= WDE_DOG_CTL_RST[WDE_DOG_PWS_BIT];
            dog_period_sel_reg <= WDE_DOG_CTL_RST[WDE_DOG_PER_MSB:WDE_DOG_PER_LSB];
        end
        else
        begin
            if (wr_dog)
            begin
                dog_enable_reg <= reg_wdata[WDE_DOG_EN_BIT];
                dog_startup_delay_en_reg <= reg_wdata[WDE_DOG_DLY_BIT];
                dog_pulse_width_sel_reg <= reg_wdata[WDE_DOG_PWS_BIT];
                dog_period_sel_reg <= reg_wdata[WDE_DOG_PER_MSB:WDE_DOG_PER_LSB];
            end
            // backup supply forces the dog off, and wins over a write
            if (on_backup)
                dog_enable_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fast_event_enable_reg <= WDE_EVT_CTL_RST[WDE_FAST_EN_BIT];
            slow_event_enable_reg <= WDE_EVT_CTL_RST[WDE_SLOW_EN_BIT];
            fast_input_clears_dog_reg <= WDE_EVT_CTL_RST[WDE_CLR_IN_BIT];
            debounce_period_sel_reg <= WDE_EVT_CTL_RST[WDE_DEB_SEL_BIT];
            fast_edge_count_sel_reg <= WDE_EVT_CTL_RST[WDE_CNT_SEL_MSB:WDE_CNT_SEL_LSB];
        end
        else if (wr_evt)
        begin
            fast_event_enable_reg <= reg_wdata[WDE_FAST_EN_BIT];
            slow_event_enable_reg <= reg_wdata[WDE_SLOW_EN_BIT];
            fast_input_clears_dog_reg <= reg_wdata[WDE_CLR_IN_BIT];
            debounce_period_sel_reg <= reg_wdata[WDE_DEB_SEL_BIT];
            fast_edge_count_sel_reg <= reg_wdata[WDE_CNT_SEL_MSB:WDE_CNT_SEL_LSB];
        end
    end

    // ----------------------------------------
    // sticky flags: a set in the clearing cycle wins
    // ----------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            dog_timeout_flag_reg <= WDE_DOG_CTL_RST[WDE_DOG_FLAG_BIT];
            fast_event_flag_reg <= WDE_EVT_CTL_RST[WDE_FAST_FLAG_BIT];
            slow_event_flag_reg <= WDE_EVT_CTL_RST[WDE_SLOW_FLAG_BIT];
        end
        else
        begin
            dog_timeout_flag_reg <= dog_timeout || (dog_timeout_flag_reg && !dog_flag_clr);
            fast_event_flag_reg <= ev.fast_hit || (fast_event_flag_reg && !fast_flag_clr);
            slow_event_flag_reg <= ev.slow_hit || (slow_event_flag_reg && !slow_flag_clr);
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata_reg <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                WDE_DOG_CTL_ADDR: reg_rdata_reg <= {dog_enable_reg, dog_timeout_flag_reg,
                    dog_startup_delay_en_reg, dog_pulse_width_sel_reg, dog_period_sel_reg};
                WDE_EVT_CTL_ADDR: reg_rdata_reg <= {fast_event_flag_reg, slow_event_flag_reg,
                    fast_event_enable_reg, slow_event_enable_reg, fast_input_clears_dog_reg,
                    debounce_period_sel_reg, fast_edge_count_sel_reg};
                default: reg_rdata_reg <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // event detector hookup
    // ----------------------------------------
    assign ev.tick = osc_tick;
    // bypass mode and backup supply both shut the fast detector
    assign ev.fast_on = fast_event_enable_reg && !fast_input_clears_dog_reg && !on_backup;
    assign ev.slow_on = slow_event_enable_reg && !on_backup;
    assign ev.deb_sel = debounce_period_sel_reg;
    assign ev.cnt_sel = fast_edge_count_sel_reg;

    wde_evdet u_evdet (
        .mclk(mclk),
        .nrst(nrst),
        .fast_event_input(fast_event_input),
        .slow_event_input(slow_event_input),
        .ev(ev)
    );

    // ----------------------------------------
    // watchdog counter
    // ----------------------------------------
    assign dog_period = wde_dog_period(dog_period_sel_reg[2:0]);

    // any of the four clear sources restarts the count
    assign dog_restart = clear_dog_instruction
        || (fast_input_clears_dog_reg && ev.fast_edge)
        || (dog_enable_reg && !dog_en_prev_reg)
        || (dog_flag_clr && dog_timeout_flag_reg);

    // a clear landing on the last tick still saves the system
    assign dog_timeout = dog_enable_reg && !dog_restart && osc_tick
        && (wd_state_reg == WDE_WD_COUNT)
        && (wd_cnt_reg == 22'(dog_period - 22'h000001));

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            dog_en_prev_reg <= 1'b0;
        else
            dog_en_prev_reg <= dog_enable_reg;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wd_state_reg <= WDE_WD_OFF;
            wd_cnt_reg <= 22'h000000;
        end
        else if (!dog_enable_reg)
        begin
            wd_state_reg <= WDE_WD_OFF;
            wd_cnt_reg <= 22'h000000;
        end
        else if (dog_restart || wd_state_reg == WDE_WD_OFF)
        begin
            wd_cnt_reg <= 22'h000000;
            wd_state_reg <= dog_startup_delay_en_reg ? WDE_WD_DELAY : WDE_WD_COUNT;
        end
        else
        begin
            case (wd_state_reg)
                WDE_WD_DELAY:
                begin
                    if (osc_tick)
                    begin
                        if (wd_cnt_reg == 22'(DELAY_CYC - 22'h000001))
                        begin
                            wd_cnt_reg <= 22'h000000;
                            wd_state_reg <= WDE_WD_COUNT;
                        end
                        else
                            wd_cnt_reg <= 22'(wd_cnt_reg + 22'h000001);
                    end
                end
                WDE_WD_COUNT:
                begin
                    if (dog_timeout)
                    begin
                        wd_cnt_reg <= 22'h000000;
                        wd_state_reg <= WDE_WD_TRIPPED;
                    end
                    else if (osc_tick)
                        wd_cnt_reg <= 22'(wd_cnt_reg + 22'h000001);
                end
                // parked until any restart source fires: flag clear, clear instruction, fast edge or re-enable
                WDE_WD_TRIPPED: wd_cnt_reg <= 22'h000000;
                default: wd_state_reg <= WDE_WD_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // dog output pulse
    // ----------------------------------------
    assign pulse_len = dog_pulse_width_sel_reg ? WDE_PULSE_LONG : WDE_PULSE_SHORT;

    // no alarm routing enters here, so the pulse always reaches the pin
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pulse_on_reg <= 1'b0;
            pulse_cnt_reg <= 13'h0000;
            dog_pin_n_reg <= 1'b1;
        end
        else if (dog_timeout)
        begin
            pulse_on_reg <= 1'b1;
            pulse_cnt_reg <= 13'h0000;
            dog_pin_n_reg <= 1'b0;
        end
        else if (pulse_on_reg && osc_tick)
        begin
            if (pulse_cnt_reg == 13'(pulse_len - 13'h0001))
            begin
                pulse_on_reg <= 1'b0;
                dog_pin_n_reg <= 1'b1;
            end
            else
                pulse_cnt_reg <= 13'(pulse_cnt_reg + 13'h0001);
        end
    end

    // ----------------------------------------
    // interrupt pin
    // ----------------------------------------
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            irq_n_reg <= 1'b1;
        else
            irq_n_reg <= !((fast_event_flag_reg && ev.fast_on)
                || (slow_event_flag_reg && ev.slow_on));
    end

    assign reg_rdata = reg_rdata_reg;
    assign dog_output_pin_n = dog_pin_n_reg;
    assign irq_n = irq_n_reg;

endmodule : wde_top

// ### test/wde_osc_model.sv
`timescale 1ns/1ns
// ----
// oscillator
// ----
module wde_osc_model (
    input wire logic mclk,
    input wire logic run,
    output logic osc_tick
);
    // one tick per mclk keeps long counts short; no tick while stopped
    always_ff @(posedge mclk)
    begin
        osc_tick <= run;
    end
endmodule : wde_osc_model

// ### test/wde_top_checker.sv
`timescale 1ns/1ns
// ----
// port checker
// ----
module wde_top_checker
    import wde_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic osc_tick,
    input wire logic on_backup,
    input wire logic clear_dog_instruction,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic dog_output_pin_n,
    input wire logic irq_n
);
    logic pws_reg;
    logic [12:0] low_reg;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // the pin has no view of the width select, so track the last write
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            pws_reg <= 1'b0;
        else if (reg_wr && reg_addr == WDE_DOG_CTL_ADDR)
            pws_reg <= reg_wdata[WDE_DOG_PWS_BIT];
    end
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            low_reg <= 13'h0000;
        else
            low_reg <= dog_output_pin_n ? 13'h0000 : 13'(low_reg + 13'(osc_tick));
    end
    sequence s_backup_held;
        on_backup [*3];
    endsequence
    sequence s_pulse_start;
        $fell(dog_output_pin_n);
    endsequence
    a_pulse_width: assert property ($rose(dog_output_pin_n) |-> low_reg == (pws_reg ? WDE_PULSE_LONG : WDE_PULSE_SHORT))
        else $error("dog pulse width wrong");
    a_pulse_min: assert property (s_pulse_start |=> !dog_output_pin_n [*3])
        else $error("dog pulse too short");
    a_fall_on_tick: assert property (s_pulse_start |-> $past(osc_tick) || $past(osc_tick, 2))
        else $error("dog timeout without oscillator tick");
    a_clear_holds: assert property (clear_dog_instruction && dog_output_pin_n |=> dog_output_pin_n [*8])
        else $error("timeout right after clear");
    a_quiet_after_pulse: assert property ($rose(dog_output_pin_n) |-> dog_output_pin_n [*8])
        else $error("second pulse while flag set");
    a_backup_no_dog: assert property (s_backup_held |-> !$fell(dog_output_pin_n))
        else $error("dog pulse on backup");
    a_backup_no_irq: assert property (s_backup_held |-> irq_n)
        else $error("irq asserted on backup");
    a_irq_fall_cause: assert property ($fell(irq_n) |-> !$past(on_backup))
        else $error("irq fell while on backup");
endmodule : wde_top_checker
bind wde_top wde_top_checker wde_top_checker_i (.mclk(mclk), .nrst(nrst), .osc_tick(osc_tick),
    .on_backup(on_backup), .clear_dog_instruction(clear_dog_instruction), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .dog_output_pin_n(dog_output_pin_n), .irq_n(irq_n));

// ### test/tb_wde_top.sv
`timescale 1ns/1ns
module tb_wde_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b1;
    logic on_backup = 1'b0;
    logic clr = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic fast = 1'b0;
    logic slow = 1'b0;
    logic osc_tick;
    logic [7:0] reg_rdata;
    logic pin_n, irq_n;
    int failures = 0;
    int checks_done = 0;
    int seed = 32'h5877;
    int n;
    int per[5] = '{32, 512, 2048, 4096, 32768};
    int need[4] = '{1, 4, 16, 32};
    logic [7:0] exp_q[$];
    wde_osc_model wde_osc_model_i (.mclk(mclk), .run(run), .osc_tick(osc_tick));
    wde_top #(.DELAY_CYC(22'h000040)) wde_top_i (.mclk(mclk), .nrst(nrst), .osc_tick(osc_tick),
        .on_backup(on_backup), .clear_dog_instruction(clr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fast_event_input(fast),
        .slow_event_input(slow), .dog_output_pin_n(pin_n), .irq_n(irq_n));
    initial forever #20 mclk = ~mclk;
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        checks_done++;
        if (!(got >= lo && got <= hi) || $isunknown(got))
        begin
            failures++;
            $display("MISMATCH %s expected %0d..%0d seen %0h", what, lo, hi, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
    endtask : rd
    // s picks the pin: 0 dog, 1 irq; cnt counts falling edges waited
    task automatic wait_for(input bit s, input logic lvl, input int max, output int cnt);
        cnt = 0;
        while (((s ? irq_n : pin_n) !== lvl) && cnt < max)
        begin
            @(negedge mclk);
            cnt++;
        end
    endtask : wait_for
    task automatic tgl(input bit s, input int k);
        repeat (k)
        begin
            repeat (3 + ($unsigned($random(seed)) % 4)) @(negedge mclk);
            if (s)
                slow = ~slow;
            else
                fast = ~fast;
        end
    endtask : tgl
    task automatic dog_on(input logic [7:0] cfg);
        wr(8'h0a, cfg);
        wr(8'h0a, cfg | 8'h80);
    endtask : dog_on
    initial
    begin
        forever
        begin
            @(posedge mclk);
            if (reg_rd === 1'b1)
            begin
                @(posedge mclk);
                #1;
                chk("reg_rdata", exp_q[0], exp_q[0], reg_rdata);
                void'(exp_q.pop_front());
            end
        end
    end
    initial
    begin
        #(40 * 95000);
        failures++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        rd(8'h0c, 8'h00);
        for (int c = 0; c < 5; c++)
        begin
            dog_on({3'b000, c == 1, c[3:0]});
            wait_for(0, 1'b0, 40000, n);
            chk("dog period", per[c], per[c] + 5, n);
            wait_for(0, 1'b1, 5000, n);
            chk("dog pulse", c == 1 ? 4096 : 4, c == 1 ? 4097 : 5, n);
            rd(8'h0a, {3'b110, c == 1, c[3:0]});
            wr(8'h0a, 8'h00);
        end
        dog_on(8'h00);
        wait_for(0, 1'b0, 60, n);
        wait_for(0, 1'b1, 10, n);
        wait_for(0, 1'b0, 100, n);
        chk("dog parked", 100, 100, n);
        rd(8'h0a, 8'hc0);
        wr(8'h0a, 8'h80);
        wait_for(0, 1'b0, 60, n);
        chk("restart by flag clear", 32, 37, n);
        wait_for(0, 1'b1, 10, n);
        dog_on(8'h20);
        wait_for(0, 1'b0, 200, n);
        chk("startup delay", 96, 101, n);
        wait_for(0, 1'b1, 10, n);
        dog_on(8'h00);
        repeat (25) @(negedge mclk);
        wr(8'h0a, 8'h00);
        wr(8'h0a, 8'h80);
        repeat (5)
        begin
            repeat (20) @(negedge mclk);
            clr = 1'b1;
            @(negedge mclk);
            clr = 1'b0;
        end
        wait_for(0, 1'b0, 60, n);
        chk("restart by clear and toggle", 30, 37, n);
        wait_for(0, 1'b1, 10, n);
        dog_on(8'h00);
        run = 1'b0;
        wait_for(0, 1'b0, 200, n);
        chk("oscillator stopped", 200, 200, n);
        run = 1'b1;
        wait_for(0, 1'b0, 60, n);
        chk("oscillator resumed", 28, 38, n);
        wait_for(0, 1'b1, 10, n);
        wr(8'h0a, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h0b, s[7:0]);
            wr(8'h0b, 8'h20 | s[7:0]);
            tgl(0, need[s] - 1);
            repeat (10) @(negedge mclk);
            chk("irq early", 1, 1, irq_n);
            tgl(0, 1);
            wait_for(1, 1'b0, 20, n);
            chk("irq after edges", 1, 10, n);
            rd(8'h0b, 8'ha0 | s[7:0]);
            wr(8'h0b, 8'h20 | s[7:0]);
            repeat (3) @(negedge mclk);
            chk("irq released", 1, 1, irq_n);
        end
        wr(8'h0b, 8'h20);
        tgl(0, 1);
        dog_on(8'h00);
        on_backup = 1'b1;
        repeat (6) @(negedge mclk);
        chk("irq on backup", 1, 1, irq_n);
        rd(8'h0a, 8'h00);
        wait_for(0, 1'b0, 60, n);
        chk("dog on backup", 60, 60, n);
        on_backup = 1'b0;
        repeat (4) @(negedge mclk);
        chk("irq after backup", 0, 0, irq_n);
        wr(8'h0b, 8'h01);
        wr(8'h0b, 8'h21);
        tgl(0, 3);
        repeat (8300) @(negedge mclk);
        tgl(0, 1);
        repeat (10) @(negedge mclk);
        chk("window expiry", 1, 1, irq_n);
        tgl(0, 3);
        wait_for(1, 1'b0, 40, n);
        chk("new window", 1, 39, n);
        wr(8'h0b, 8'h28);
        dog_on(8'h00);
        tgl(0, 20);
        wait_for(0, 1'b0, 60, n);
        chk("fast edges clear dog", 30, 40, n);
        chk("fast detector off", 1, 1, irq_n);
        wait_for(0, 1'b1, 10, n);
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h00);
        wr(8'h0b, 8'h10);
        slow = ~slow;
        repeat (500) @(negedge mclk);
        slow = ~slow;
        repeat (1100) @(negedge mclk);
        chk("bounce ignored", 1, 1, irq_n);
        slow = ~slow;
        wait_for(1, 1'b0, 1100, n);
        chk("short debounce", 1024, 1032, n);
        rd(8'h0b, 8'h50);
        wr(8'h0b, 8'h14);
        @(negedge mclk) slow = ~slow;
        wait_for(1, 1'b0, 16500, n);
        chk("long debounce", 16384, 16392, n);
        stop_test();
    end
endmodule : tb_wde_top
